// file: core/seps_top.sv
// Serial EEPROM command front end with write latch and block protection.
// Assumes an SPI master in mode 0 or 3 with SCK far slower than clk_i.
// Contract
// [R01] Opcodes shift into an eight-bit register
// [R02] Master holds chip select low throughout
// [R03] All fields move most significant bit first
// [R04] Sample input on each rising clock edge
// [R05] Change output on falling clock edges
// [R06] Halted serial clock resumes at same bit
// [R07] No write while the latch is clear
// [R08] Opcode 06h sets the write latch
// [R09] Opcode 04h clears the write latch
// [R10] Latch clears at reset and write end
// [R11] Status read accepted even while busy
// [R12] Status: zeros, watchdog bits, lock bits
// [R13] Opcode 01h loads the next status byte
// [R14] Lock field selects one of eight ranges
// [R15] Locked ranges read fine, refuse writes
// [R16] Lock selection held until next status write; reset here reloads STATUS_FACTORY
// [R17] Opcode 05h shifts out the status byte
// [R18] Opcode 02h takes address then write data
// [R19] Opcode 03h takes address, returns data
// [R20] Writing 00h at 01h raises trip threshold
// [R21] Writing 00h at 03h lowers trip threshold
// [R22] Enabled watchdog resets on missing activity
// [R23] Period bits choose timeout or disable
// [R24] Busy status read returns one first
// [R25] Write completes only on byte boundary
// [R26] Latch set must end with chip select
// [R27] Unknown opcodes ignored until deselect
module seps_top #(
	parameter int unsigned WRITE_CYC = seps_pkg::WRITE_CYCLES,
	parameter int unsigned WD_T0_CYC = seps_pkg::WD_T0_CYCLES,
	parameter int unsigned WD_T1_CYC = seps_pkg::WD_T1_CYCLES,
	parameter int unsigned WD_T2_CYC = seps_pkg::WD_T2_CYCLES,
	parameter int unsigned HOLD_CYC  = seps_pkg::RST_HOLD_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic cs_n_i,
	input  wire logic sck_i,
	input  wire logic si_i,
	input  wire logic wp_n_i,
	output logic      so_o,
	output logic      so_oe_o,
	output logic      reset_o,
	output logic      reset_oe_o,
	output logic      trip_raise_o,
	output logic      trip_lower_o
);
	import seps_pkg::*;

	if (WRITE_CYC <= COMMIT_CYCLES || HOLD_CYC == 0) begin : g_bad_param
		$error("seps_top: write or reset hold time too short");
	end

	logic                cs_m;
	logic                cs_s;
	logic                cs_d;
	logic                sck_m;
	logic                sck_s;
	logic                sck_d;
	logic                si_m;
	logic                si_s;
	logic                wp_m;
	logic                wp_s;
	logic                cs_fall;
	logic                cs_rise;
	logic                sck_rise;
	logic                sck_fall;
	logic                byte_done;
	logic [7:0]          rx_sh;
	logic [7:0]          shift_in;
	logic [2:0]          bit_cnt;
	seps_state_e         state;
	logic                addr_second;
	logic                is_write;
	logic [15:0]         addr;
	logic [15:0]         start_addr;
	logic [PAGE_W-1:0]   wr_idx;
	logic [1:0]          data_cnt;
	logic [7:0]          first_byte;
	logic [2**PAGE_W-1:0] slot_valid;
	logic                wel;
	logic [NV_W-1:0]     status_nv;
	logic [NV_W-1:0]     status_pend;
	logic [7:0]          status_byte;
	logic                busy;
	logic [31:0]         busy_cnt;
	logic                commit_run;
	logic                commit_wr;
	logic [PAGE_W-1:0]   commit_idx;
	logic [PAGE_W-1:0]   commit_idx_d;
	logic                array_go;
	logic                status_go;
	logic                write_done;
	logic [7:0]          tx_sh;
	logic                load_pend;
	logic [ADDR_W-1:0]   rd_addr;
	logic [ADDR_W-1:0]   arr_addr;
	logic                rd_start;
	logic                rd_next;
	logic                arr_re;
	logic                arr_we;
	logic [7:0]          arr_rdata;
	logic                buf_we;
	logic [7:0]          buf_rdata;
	logic                wd_fire;

	// Two-flop synchronisers; cs and sck also feed a third delay flop to the edge detectors
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cs_m  <= 1'b1;
			cs_s  <= 1'b1;
			cs_d  <= 1'b1;
			sck_m <= 1'b0;
			sck_s <= 1'b0;
			sck_d <= 1'b0;
			si_m  <= 1'b0;
			si_s  <= 1'b0;
			wp_m  <= 1'b0;
			wp_s  <= 1'b0;
		end else begin
			cs_m  <= cs_n_i;
			cs_s  <= cs_m;
			cs_d  <= cs_s;
			sck_m <= sck_i;
			sck_s <= sck_m;
			sck_d <= sck_s;
			si_m  <= si_i;
			si_s  <= si_m;
			wp_m  <= wp_n_i;
			wp_s  <= wp_m;
		end
	end

	assign cs_fall   = cs_d & ~cs_s;
	assign cs_rise   = ~cs_d & cs_s;
	// Edges only count while selected, so a stopped clock just waits
	assign sck_rise  = ~cs_s & ~cs_fall & sck_s & ~sck_d; // see [R04] [R06]
	assign sck_fall  = ~cs_s & ~sck_s & sck_d; // see [R05]
	assign shift_in  = {rx_sh[6:0], si_s}; // see [R01] [R03]
	assign byte_done = sck_rise && (bit_cnt == BIT_LAST);

	// Command sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state       <= ST_IDLE;
			rx_sh       <= '0;
			bit_cnt     <= '0;
			addr_second <= 1'b0;
			is_write    <= 1'b0;
		end else if (cs_s) begin
			state   <= ST_IDLE;
			bit_cnt <= '0;
		end else if (cs_fall) begin
			state       <= ST_OPCODE;
			bit_cnt     <= '0;
			addr_second <= 1'b0;
		end else if (sck_rise) begin
			rx_sh   <= shift_in;
			bit_cnt <= bit_cnt + 3'h1;
			case (state)
				ST_OPCODE: begin
					if (byte_done) begin
						is_write <= (shift_in == OP_ARRAY_WRITE);
						if (busy && shift_in != OP_STATUS_READ) begin
							state <= ST_IGNORE; // see [R11]
						end else begin
							case (shift_in)
								OP_LATCH_SET:    state <= ST_LATCH_SET_CMD_END;
								OP_STATUS_READ:  state <= ST_STAT_OUT;
								OP_ARRAY_READ:   state <= ST_ADDR;
								OP_STATUS_WRITE: state <= (wel && wp_s)
									? ST_STAT_IN : ST_IGNORE; // see [R07]
								OP_ARRAY_WRITE:  state <= (wel && wp_s)
									? ST_ADDR : ST_IGNORE; // see [R07]
								default:         state <= ST_IGNORE; // see [R27]
							endcase
						end
					end
				end
				ST_ADDR: begin
					if (byte_done) begin
						addr_second <= 1'b1;
						if (addr_second) begin
							state <= is_write ? ST_WDATA : ST_RDATA;
						end
					end
				end
				ST_STAT_IN: begin
					if (byte_done) begin
						state <= ST_STAT_END;
					end
				end
				// Any extra clock spoils a pending latch set or status write
				ST_STAT_END: state <= ST_IGNORE; // see [R25]
				ST_LATCH_SET_CMD_END: state <= ST_IGNORE; // see [R26]
				default:     state <= state;
			endcase
		end
	end

	// Address, page staging and write bookkeeping
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr        <= '0;
			start_addr  <= '0;
			wr_idx      <= '0;
			data_cnt    <= '0;
			first_byte  <= '0;
			slot_valid  <= '0;
			status_pend <= '0;
		end else begin
			if (cs_fall && !busy) begin
				slot_valid <= '0;
				data_cnt   <= '0;
			end
			if (byte_done && state == ST_ADDR) begin
				addr <= {addr[7:0], shift_in}; // see [R03]
				if (addr_second) begin
					start_addr <= {addr[7:0], shift_in};
					wr_idx     <= shift_in[PAGE_W-1:0];
				end
			end
			if (byte_done && state == ST_WDATA) begin // see [R18]
				// Page wrap: the index rolls within the same page
				wr_idx <= wr_idx + 1'b1;
				slot_valid[wr_idx] <= !seps_locked(
					status_nv[LOCK_MSB:LOCK_LSB],
					{addr[ADDR_W-1:PAGE_W], wr_idx}); // see [R14] [R15]
				if (data_cnt == 2'h0) begin
					first_byte <= shift_in;
				end
				if (data_cnt != 2'h3) begin
					data_cnt <= data_cnt + 2'h1;
				end
			end
			if (byte_done && state == ST_STAT_IN) begin
				status_pend <= shift_in[NV_W-1:0]; // see [R13]
			end
		end
	end

	assign buf_we = byte_done && state == ST_WDATA;

	// A write commits only when deselected exactly on a byte boundary
	assign array_go  = cs_rise && state == ST_WDATA && bit_cnt == BIT_FIRST
		&& data_cnt != 2'h0; // see [R25]
	assign status_go = cs_rise && state == ST_STAT_END; // see [R25]

	// Nonvolatile write cycle timing and page commit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy         <= 1'b0;
			busy_cnt     <= '0;
			commit_run   <= 1'b0;
			commit_wr    <= 1'b0;
			commit_idx   <= '0;
			commit_idx_d <= '0;
			write_done   <= 1'b0;
			status_nv    <= STATUS_FACTORY;
		end else begin
			write_done   <= 1'b0;
			commit_wr    <= commit_run;
			commit_idx_d <= commit_idx;
			if (array_go || status_go) begin
				busy       <= 1'b1;
				busy_cnt   <= 32'(WRITE_CYC - 1);
				commit_run <= array_go;
				commit_idx <= '0;
				if (status_go) begin
					status_nv <= status_pend; // see [R13] [R16]
				end
			end else if (busy) begin
				busy_cnt <= busy_cnt - 32'h1;
				if (commit_run) begin
					commit_idx <= commit_idx + 1'b1;
					if (commit_idx == '1) begin
						commit_run <= 1'b0;
					end
				end
				if (busy_cnt == '0) begin
					busy       <= 1'b0;
					write_done <= 1'b1;
				end
			end
		end
	end

	assign arr_we = commit_wr && slot_valid[commit_idx_d];

	// Write latch; a set on deselect wins over a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wel <= 1'b0; // see [R10]
		end else if (cs_rise && state == ST_LATCH_SET_CMD_END) begin
			wel <= 1'b1; // see [R08] [R26]
		end else if (write_done) begin
			wel <= 1'b0; // see [R10]
		end else if (byte_done && state == ST_OPCODE
			&& shift_in == OP_LATCH_CLEAR && !busy) begin
			wel <= 1'b0; // see [R09]
		end
	end

	// Trip threshold programming strobes on a committed one-byte write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trip_raise_o <= 1'b0;
			trip_lower_o <= 1'b0;
		end else begin
			trip_raise_o <= array_go && data_cnt == 2'h1
				&& first_byte == TRIP_DATA
				&& start_addr == TRIP_RAISE_ADDR; // see [R20]
			trip_lower_o <= array_go && data_cnt == 2'h1
				&& first_byte == TRIP_DATA
				&& start_addr == TRIP_LOWER_ADDR; // see [R21]
		end
	end

	// Array read addressing; rolls over at the top of the array
	assign rd_start = byte_done && state == ST_ADDR && addr_second
		&& !is_write;
	assign rd_next  = byte_done && state == ST_RDATA;
	assign arr_re   = rd_start || rd_next;

	always_comb begin
		if (commit_wr) begin
			arr_addr = {addr[ADDR_W-1:PAGE_W], commit_idx_d};
		end else if (rd_start) begin
			arr_addr = {addr[ADDR_W-9:0], shift_in};
		end else begin
			arr_addr = rd_addr + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_addr   <= '0;
			load_pend <= 1'b0;
		end else begin
			load_pend <= arr_re;
			if (arr_re) begin
				rd_addr <= arr_addr; // see [R19]
			end
		end
	end

	assign status_byte = {busy, 2'h0, status_nv}; // see [R12] [R24]

	// Output shifter; bits leave on falling edges, MSB first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_sh   <= '0;
			so_o    <= 1'b0;
			so_oe_o <= 1'b0;
		end else begin
			so_oe_o <= ~cs_s && (state == ST_STAT_OUT
				|| state == ST_RDATA); // see [R27]
			if (load_pend) begin
				tx_sh <= arr_rdata; // see [R19]
			end else if ((byte_done && state == ST_OPCODE
				&& shift_in == OP_STATUS_READ)
				|| (byte_done && state == ST_STAT_OUT)) begin
				tx_sh <= status_byte; // see [R17] [R11]
			end else if (sck_fall) begin
				so_o  <= tx_sh[7]; // see [R05] [R03]
				tx_sh <= {tx_sh[6:0], 1'b0};
			end
		end
	end

	// Open-drain reset output: the pin only ever pulls low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reset_o    <= 1'b0;
			reset_oe_o <= 1'b0;
		end else begin
			reset_o    <= 1'b0;
			reset_oe_o <= wd_fire; // see [R22]
		end
	end

	seps_mem #(
		.AW (ADDR_W),
		.DW (DATA_W)
	) u_array (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.we_i    (arr_we),
		.re_i    (arr_re),
		.addr_i  (arr_addr),
		.wdata_i (buf_rdata),
		.rdata_o (arr_rdata)
	);

	// Page staging so an aborted write never touches the array
	seps_mem #(
		.AW (PAGE_W),
		.DW (DATA_W)
	) u_page (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.we_i    (buf_we),
		.re_i    (commit_run),
		.addr_i  (buf_we ? wr_idx : commit_idx),
		.wdata_i (shift_in),
		.rdata_o (buf_rdata)
	);

	seps_wdog #(
		.T0   (WD_T0_CYC),
		.T1   (WD_T1_CYC),
		.T2   (WD_T2_CYC),
		.HOLD (HOLD_CYC)
	) u_wdog (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.kick_i   (cs_fall),
		.period_i (status_nv[WD_HI_BIT:WD_LO_BIT]), // see [R23]
		.fire_o   (wd_fire)
	);
endmodule

// file: core/seps_pkg.sv
// Shared constants for the serial EEPROM command and protection front end.
// Assumes a single 10 MHz system clock sampling all serial pins.
package seps_pkg;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int PAGE_W = 4;

	localparam logic [7:0] OP_LATCH_SET    = 8'h06;
	localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_STATUS_READ  = 8'h05;
	localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;
	localparam logic [7:0] OP_ARRAY_READ   = 8'h03;

	localparam logic [2:0] BIT_LAST  = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;

	// Status byte layout
	localparam int ST_WIP_BIT = 7;
	localparam int WD_HI_BIT  = 4;
	localparam int WD_LO_BIT  = 3;
	localparam int LOCK_MSB   = 2;
	localparam int LOCK_LSB   = 0;
	localparam int NV_W       = 5;

	localparam logic [1:0] WD_1400MS = 2'h0;
	localparam logic [1:0] WD_600MS  = 2'h1;
	localparam logic [1:0] WD_200MS  = 2'h2;
	localparam logic [1:0] WD_OFF    = 2'h3;
	localparam logic [NV_W-1:0] STATUS_FACTORY = 5'h18;

	localparam logic [15:0] TRIP_RAISE_ADDR = 16'h0001;
	localparam logic [15:0] TRIP_LOWER_ADDR = 16'h0003;
	localparam logic [7:0]  TRIP_DATA       = 8'h00;

	localparam longint CLK_PERIOD_NS = 100;
	localparam longint NS_PER_MS     = 1000000;
	localparam longint WRITE_TIME_NS = 5000000;
	localparam longint WD_T0_MS      = 1400;
	localparam longint WD_T1_MS      = 600;
	localparam longint WD_T2_MS      = 200;
	localparam longint RST_HOLD_MS   = 250;
	localparam int WRITE_CYCLES = int'(WRITE_TIME_NS / CLK_PERIOD_NS);
	localparam int WD_T0_CYCLES = int'(WD_T0_MS * NS_PER_MS / CLK_PERIOD_NS);
	localparam int WD_T1_CYCLES = int'(WD_T1_MS * NS_PER_MS / CLK_PERIOD_NS);
	localparam int WD_T2_CYCLES = int'(WD_T2_MS * NS_PER_MS / CLK_PERIOD_NS);
	localparam int RST_HOLD_CYCLES = int'(RST_HOLD_MS * NS_PER_MS
		/ CLK_PERIOD_NS);
	localparam int COMMIT_CYCLES = (2 ** PAGE_W) + 1;

	// Protected ranges per lock selection; entry 0 can never match
	localparam logic [ADDR_W-1:0] LOCK_LO [8] = '{10'h3FF, 10'h000,
		10'h100, 10'h200, 10'h300, 10'h000, 10'h000, 10'h3F0};
	localparam logic [ADDR_W-1:0] LOCK_HI [8] = '{10'h000, 10'h0FF,
		10'h1FF, 10'h2FF, 10'h3FF, 10'h1FF, 10'h00F, 10'h3FF};

	typedef enum logic [3:0] {
		ST_IDLE, ST_OPCODE, ST_ADDR, ST_WDATA, ST_RDATA, ST_STAT_OUT,
		ST_STAT_IN, ST_STAT_END, ST_LATCH_SET_CMD_END, ST_IGNORE
	} seps_state_e;

	function automatic logic seps_locked(input logic [2:0] sel,
		input logic [ADDR_W-1:0] addr);
		return (addr >= LOCK_LO[sel]) && (addr <= LOCK_HI[sel]);
	endfunction

endpackage

// file: core/seps_mem.sv
// Single-port byte memory with registered read data.
// Assumes one access per cycle; contents are not cleared by reset.
module seps_mem #(
	parameter int AW = 10,
	parameter int DW = 8
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          we_i,
	input  wire logic          re_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] wdata_i,
	output logic      [DW-1:0] rdata_o
);
	logic [DW-1:0] cells [2**AW];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			cells[addr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else if (re_i) begin
			rdata_o <= cells[addr_i];
		end
	end
endmodule

// file: core/seps_wdog.sv
// Watchdog timer: restarts on each kick, fires a held reset on expiry.
// Assumes kick_i is a one-cycle pulse from the chip select falling edge.
module seps_wdog
	import seps_pkg::*;
#(
	parameter int unsigned T0   = WD_T0_CYCLES,
	parameter int unsigned T1   = WD_T1_CYCLES,
	parameter int unsigned T2   = WD_T2_CYCLES,
	parameter int unsigned HOLD = RST_HOLD_CYCLES
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       kick_i,
	input  wire logic [1:0] period_i,
	output logic            fire_o
);
	logic [31:0] cnt;
	logic [31:0] hold_cnt;
	logic [31:0] limit;

	always_comb begin
		case (period_i)
			WD_1400MS: limit = 32'(T0);
			WD_600MS:  limit = 32'(T1);
			WD_200MS:  limit = 32'(T2);
			default:   limit = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt      <= '0;
			hold_cnt <= '0;
			fire_o   <= 1'b0;
		end else if (fire_o) begin
			cnt <= '0;
			if (hold_cnt == 32'(HOLD - 1)) begin
				fire_o <= 1'b0;
			end
			hold_cnt <= hold_cnt + 32'h1;
		end else if (period_i == WD_OFF || kick_i) begin
			cnt <= '0;
		end else if (cnt >= limit - 32'h1) begin
			fire_o   <= 1'b1; // see [R22]
			hold_cnt <= '0;
		end else begin
			cnt <= cnt + 32'h1;
		end
	end
endmodule

// file: verification/seps_top_properties.sv
// Timing checks on the ports of the serial front end.
// Assumes the pins are driven at clk_i rising edges.
module seps_top_properties #(
	parameter int unsigned WD_T2_CYC = 100
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic so_o,
	input wire logic so_oe_o,
	input wire logic reset_o,
	input wire logic reset_oe_o,
	input wire logic trip_raise_o,
	input wire logic trip_lower_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned idle_cnt;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Saturates so a long idle span cannot wrap to a small count
	always_ff @(posedge clk_i) begin
		if (rst_i || $fell(cs_n_i))
			idle_cnt <= 0;
		else if (idle_cnt < 32'hFFFF)
			idle_cnt <= idle_cnt + 1;
	end
	a_so_on_fall: assert property (
		so_oe_o && $past(so_oe_o) && $changed(so_o)
		|-> !$past(sck_i, 3) || !$past(sck_i, 4))
		else $error("serial output moved away from a clock fall");
	a_oe_after_rise: assert property (
		$rose(so_oe_o) |-> $past(sck_i, 3) || $past(sck_i, 4))
		else $error("output enable rose away from a clock rise");
	a_oe_quiet: assert property (
		so_oe_o |-> !$past(cs_n_i, 8))
		else $error("output driven while deselected");
	a_trip_pulse: assert property (
		trip_raise_o || trip_lower_o |=> !trip_raise_o && !trip_lower_o)
		else $error("trip pulse longer than one cycle");
	a_trip_on_cs: assert property (
		trip_raise_o || trip_lower_o
		|-> cs_n_i && $past(cs_n_i, 2) && !$past(cs_n_i, 9))
		else $error("trip pulse without chip select rise");
	a_trip_alone: assert property (
		!(trip_raise_o && trip_lower_o))
		else $error("both trip pulses at once");
	a_wdog_idle: assert property (
		$rose(reset_oe_o) |-> idle_cnt >= WD_T2_CYC)
		else $error("watchdog fired too early");
	a_wdog_hold: assert property (
		$rose(reset_oe_o) |=> reset_oe_o [*8])
		else $error("reset pulse too short");
	a_reset_drive: assert property (
		reset_oe_o |-> reset_o == 1'b0)
		else $error("reset pin not driven low");
endmodule
bind seps_top seps_top_properties #(.WD_T2_CYC(WD_T2_CYC))
	i_seps_top_properties (.clk_i(clk_i), .rst_i(rst_i),
	.cs_n_i(cs_n_i), .sck_i(sck_i), .so_o(so_o), .so_oe_o(so_oe_o),
	.reset_o(reset_o), .reset_oe_o(reset_oe_o),
	.trip_raise_o(trip_raise_o), .trip_lower_o(trip_lower_o));

// file: verification/seps_spi_master.sv
// Mode 0 SPI master model with frame-level operations.
// Assumes a 100 ns clk_i; SCK period is eight clocks.
module seps_spi_master (
	input  wire logic clk_i,
	input  wire logic so_i,
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      si_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import seps_pkg::*;
	logic [7:0] rx;
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Held low from first bit to last
	task automatic sel();
		tick(1);
		cs_n_o <= 1'b0;
		tick(4);
	endtask
	// Every command frame ends with a deselect
	task automatic desel();
		tick(4);
		cs_n_o <= 1'b1;
		si_o <= ~si_o;
		tick(12);
	endtask
	// MSB first, data set up before each rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx_o,
		input int nb = 8, input int stall = 0);
		rx_o = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			// Clock parked low mid-byte when a stall is asked for
			if (i == 3)
				tick(stall);
			si_o <= tx[i];
			tick(4);
			sck_o <= 1'b1;
			tick(4);
			rx_o[i] = so_i;
			sck_o <= 1'b0;
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		sel();
		xfer(op, rx);
		desel();
	endtask
	task automatic stat(output logic [7:0] s);
		sel();
		xfer(OP_STATUS_READ, rx);
		xfer(8'h00, s);
		desel();
	endtask
	task automatic swr(input logic [7:0] v);
		cmd(OP_LATCH_SET);
		sel();
		xfer(OP_STATUS_WRITE, rx);
		xfer(v, rx);
		desel();
	endtask
	// Mode 0 no latch, 1 latch, 2 latch in same frame, 3 latch then clear
	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		input int mode = 1, input int nb = 8);
		if (mode == 1 || mode == 3)
			cmd(OP_LATCH_SET);
		if (mode == 3)
			cmd(OP_LATCH_CLEAR);
		sel();
		if (mode == 2)
			xfer(OP_LATCH_SET, rx);
		xfer(OP_ARRAY_WRITE, rx);
		xfer(a[15:8], rx);
		xfer(a[7:0], rx);
		xfer(d, rx, nb);
		desel();
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d,
		input logic [7:0] op = OP_ARRAY_READ, input int stall = 0);
		sel();
		xfer(op, rx);
		xfer(a[15:8], rx);
		xfer(a[7:0], rx, 8, stall);
		xfer(8'h00, d, 8, stall);
		desel();
	endtask
endmodule

// file: verification/seps_top_tb.sv
// Self-checking bench for the serial command front end.
// Assumes shortened write, watchdog and reset-hold counts set below.
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("wrong value at %0t ns: got %h expected %h", $time, a, e); \
	end end
module seps_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import seps_pkg::*;
	logic clk, rst, wp_n, so_w, cs_n, sck, si;
	logic so_last = 1'b0;
	logic so, so_oe, rst_pin, rst_oe, t_raise, t_lower;
	logic [7:0] s, d;
	int miscompares, n_checks, n_raise, n_lower, n_oe, n_rst;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Released output shows the inverse of its last value
	assign so_w = so_oe ? so : ~so_last;
	always @(posedge clk) begin
		if (so_oe === 1'b1)
			so_last <= so;
		n_raise += (t_raise === 1'b1);
		n_lower += (t_lower === 1'b1);
		n_oe += (so_oe === 1'b1);
		n_rst += (rst_oe === 1'b1);
	end
	// Period codes other than the shortest keep their long defaults
	seps_top #(.WRITE_CYC(200), .WD_T2_CYC(100), .HOLD_CYC(20))
		i_seps_top (.clk_i(clk),
		.rst_i(rst), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
		.wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe), .reset_o(rst_pin),
		.reset_oe_o(rst_oe), .trip_raise_o(t_raise),
		.trip_lower_o(t_lower));
	seps_spi_master i_seps_spi_master (.clk_i(clk), .so_i(so_w),
		.cs_n_o(cs_n), .sck_o(sck), .si_o(si));
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wait_idle();
		s = 8'h80;
		for (int k = 0; k < 10 && s[7] !== 1'b0; k++)
			i_seps_spi_master.stat(s);
		`CHK(s[7], 1'b0)
	endtask
	task automatic t_write();
		i_seps_spi_master.stat(s);
		`CHK(s, {3'h0, STATUS_FACTORY})
		i_seps_spi_master.wr(16'h0105, 8'hA5);
		i_seps_spi_master.stat(s);
		`CHK(s[7], 1'b1)
		wait_idle();
		i_seps_spi_master.rd(16'h0105, d);
		`CHK(d, 8'hA5)
		$display("write and read test done");
	endtask
	// Last pass sets the latch but holds the write protect pin low
	task automatic t_refuse();
		int modes [5] = '{0, 2, 3, 1, 1};
		for (int m = 0; m < 5; m++) begin
			wp_n <= (m != 4);
			i_seps_spi_master.wr(16'h0105, 8'h00, modes[m], m == 3 ? 5 : 8);
			i_seps_spi_master.stat(s);
			`CHK(s[7], 1'b0)
			i_seps_spi_master.rd(16'h0105, d);
			`CHK(d, 8'hA5)
		end
		wp_n <= 1'b1;
		$display("refused write test done");
	endtask
	task automatic t_lock();
		for (int k = 0; k < 8; k++) begin
			i_seps_spi_master.swr({5'h03, k[2:0]});
			wait_idle();
			i_seps_spi_master.stat(s);
			`CHK(s, {5'h03, k[2:0]})
		end
		i_seps_spi_master.swr(8'h1D);
		wait_idle();
		i_seps_spi_master.wr(16'h0105, 8'h77);
		wait_idle();
		i_seps_spi_master.rd(16'h0105, d);
		`CHK(d, 8'hA5)
		i_seps_spi_master.wr(16'h0205, 8'h66);
		wait_idle();
		// Serial clock halted mid-byte on address and data
		i_seps_spi_master.rd(16'h0205, d, OP_ARRAY_READ, 40);
		`CHK(d, 8'h66)
		i_seps_spi_master.swr(8'h18);
		wait_idle();
		$display("lock test done");
	endtask
	task automatic t_trip();
		i_seps_spi_master.wr(TRIP_RAISE_ADDR, TRIP_DATA);
		wait_idle();
		i_seps_spi_master.wr(TRIP_LOWER_ADDR, TRIP_DATA);
		wait_idle();
		`CHK(n_raise, 1)
		`CHK(n_lower, 1)
		i_seps_spi_master.rd(TRIP_RAISE_ADDR, d);
		`CHK(d, TRIP_DATA)
		n_oe = 0;
		i_seps_spi_master.rd(16'h0001, d, 8'hFB);
		`CHK(n_oe, 0)
		$display("trip and unknown opcode test done");
	endtask
	task automatic t_wdog();
		i_seps_spi_master.swr(8'h10);
		wait_idle();
		n_rst = 0;
		repeat (300) @(posedge clk);
		`CHK(n_rst > 0, 1'b1)
		// Latch set just before reset must not survive it
		i_seps_spi_master.cmd(OP_LATCH_SET);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		i_seps_spi_master.stat(s);
		`CHK(s, {3'h0, STATUS_FACTORY})
		i_seps_spi_master.wr(16'h0105, 8'h11, 0);
		i_seps_spi_master.stat(s);
		`CHK(s[7], 1'b0)
		$display("watchdog test done");
	endtask
	initial begin
		rst = 1'b1;
		wp_n = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_write();
		t_refuse();
		t_lock();
		t_trip();
		t_wdog();
		tally_and_finish();
	end
	initial begin
		#5000000;
		miscompares++;
		tally_and_finish();
	end
endmodule
